// [hw/dqf_debug_qual.sv]
// What this block does
// - asynchronous reset clears all extension bits
// - end-run reset need not force extension values
// - enabled, begin clear: extensions survive end-run reset
// - B enable bit 7 adds direction
// - B value bit 6: 0 write, 1 read
// - full modes use A direction bits
// - C enable bit 7 adds direction
// - C value bit 6: 0 write, 1 read
// - reserved bits ignore writes, read zero
// - extension bit 7 flags paged access
// - unpaged entry: address bit 16 zero
// - paged entry: page bits over address
// - extension bit 0 is address bit 16
// - control register at offset 0x0C
// - A value bit: 0 write, 1 read
// - low byte read advances trace pointer
// - secure mode forces enable off
`timescale 1ns/1ps

module dqf_debug_qual
  import dqf_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic END_RUN_RST,
  input wire logic SECURE,
  input wire logic BUS_RNW,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [2:0] PAGE_REG,
  input wire logic PAGE_SEL,
  input wire logic CAPTURE,
  input wire logic EVENT_ONLY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic DEBUG_ENABLE,
  output logic ARMED,
  output logic FULL_MODE,
  output logic DIR_OK_A,
  output logic DIR_OK_B,
  output logic DIR_OK_C
);

  localparam int CW = $clog2(DEPTH+1);

  // any offset not listed, misaligned ones too, decodes to none and is refused
  function automatic dqf_reg_e reg_decode(input logic [7:0] a);
    case (a)
      OFS_CAX: reg_decode = REG_CAX;
      OFS_CBX: reg_decode = REG_CBX;
      OFS_CCX: reg_decode = REG_CCX;
      OFS_CTRL: reg_decode = REG_CTRL;
      OFS_FX: reg_decode = REG_FX;
      OFS_FH: reg_decode = REG_FH;
      OFS_FL: reg_decode = REG_FL;
      OFS_CFG: reg_decode = REG_CFG;
      OFS_STAT: reg_decode = REG_STAT;
      default: reg_decode = REG_NONE;
    endcase
  endfunction

  // a cleared enable passes every cycle; a set enable asks for rnw == value
  function automatic logic dir_ok(input logic en, input logic val, input logic rnw);
    dir_ok = !en || (val == rnw);
  endfunction

  // registers
  logic [7:0] cax;
  logic [7:0] cbx;
  logic [7:0] ccx;
  logic [7:0] ctrl;
  logic [7:0] cfg;

  // write channel state
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic bvalid;
  logic [1:0] bresp;

  // read channel state
  logic rvalid;
  logic [1:0] rresp;
  logic [7:0] rbyte;

  // direction qualifiers
  logic dir_a;
  logic dir_b;
  logic dir_c;

  // trace store
  dqf_entry_s head;
  dqf_entry_s cap_entry;
  logic st_empty;
  logic st_full;
  logic [CW-1:0] st_count;

  // write path: each half is held until both are in; a lone half keeps its
  // ready low, so a second address cannot overtake the first
  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire do_write = aw_held && w_held && !bvalid;

  wire dqf_reg_e wr_reg = reg_decode(aw_addr);
  // lane 0 strobe low still answers okay, but nothing is written
  wire wr_en = do_write && w_lane0;
  wire wr_cax = wr_en && (wr_reg == REG_CAX);
  wire wr_cbx = wr_en && (wr_reg == REG_CBX);
  wire wr_ccx = wr_en && (wr_reg == REG_CCX);
  wire wr_ctrl = wr_en && (wr_reg == REG_CTRL);
  wire wr_cfg = wr_en && (wr_reg == REG_CFG);
  wire [1:0] next_bresp = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;

  // only masked bits store: the two direction bits, cfg bits 1:0, ctrl bits 7:4 and 0; other bits drop the write
  wire [7:0] next_cax = wr_cax ? (w_byte & DIR_WMASK) : cax;
  wire [7:0] next_cbx = wr_cbx ? (w_byte & DIR_WMASK) : cbx;
  wire [7:0] next_ccx = wr_ccx ? (w_byte & DIR_WMASK) : ccx;
  wire [7:0] next_cfg = wr_cfg ? (w_byte & CFG_WMASK) : cfg;
  wire [7:0] ctrl_wr = wr_ctrl ? (w_byte & CTRL_WMASK) : ctrl;

  // secure mode holds the enable low, so it cannot be set either
  wire [7:0] sec_clear = SECURE ? (8'h01 << CTRL_EN_BIT) : 8'h00;
  // an end-run reset disarms the trace but keeps the other control bits
  wire [7:0] arm_clear = END_RUN_RST ? (8'h01 << CTRL_ARM_BIT) : 8'h00;
  wire [7:0] next_ctrl = ctrl_wr & ~sec_clear & ~arm_clear;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_byte <= S_AXI_WDATA[7:0];
        w_lane0 <= S_AXI_WSTRB[0];
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= next_bresp;
      end
      else if (S_AXI_BREADY)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;

  // register file: the asynchronous reset stands for power-on and every
  // reset that is not an end-run reset; END_RUN_RST leaves these untouched except the arm bit of ctrl, which it clears,
  // whether or not the trace had enable set and begin clear
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cax <= EXT_RESET;
      cbx <= EXT_RESET;
      ccx <= EXT_RESET;
      ctrl <= CTRL_RESET;
      cfg <= CFG_RESET;
    end
    else
    begin
      cax <= next_cax;
      cbx <= next_cbx;
      ccx <= next_ccx;
      ctrl <= next_ctrl;
      cfg <= next_cfg;
    end
  end

  // read path: data is latched at the address edge, so a pop in that same
  // edge cannot mix two entries
  assign S_AXI_ARREADY = !rvalid;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire dqf_reg_e rd_reg = reg_decode(S_AXI_ARADDR);

  wire [7:0] fx_byte = (8'(head.paged_access_flag) << FX_PAGED_BIT)
    | (8'(head.addr[16]) << FX_MSB_BIT);
  // count fills the low bits; depths above 63 would run into the flags
  wire [7:0] stat_byte = (8'(st_full) << STAT_FULL_BIT)
    | (8'(st_empty) << STAT_EMPTY_BIT) | 8'(st_count);

  logic [7:0] next_rbyte;
  always_comb
  begin
    case (rd_reg)
      REG_CAX: next_rbyte = cax;
      REG_CBX: next_rbyte = cbx;
      REG_CCX: next_rbyte = ccx;
      REG_CTRL: next_rbyte = ctrl;
      REG_FX: next_rbyte = fx_byte;
      REG_FH: next_rbyte = head.addr[15:8];
      REG_FL: next_rbyte = head.addr[7:0];
      REG_CFG: next_rbyte = cfg;
      REG_STAT: next_rbyte = stat_byte;
      default: next_rbyte = 8'h00;
    endcase
  end

  wire [1:0] next_rresp = (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
  // the pointer moves only on the low byte, so the extension and high byte
  // of an entry must be read first
  wire pop = ar_take && (rd_reg == REG_FL);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rbyte <= 8'h00;
    end
    else
    begin
      if (ar_take)
      begin
        rvalid <= 1'b1;
        rresp <= next_rresp;
        rbyte <= next_rbyte;
      end
      else if (S_AXI_RREADY)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = {24'h00_0000, rbyte};

  // trace capture: a capture while the store is full is dropped, never
  // overwritten, so the oldest entries survive for software
  wire push = CAPTURE && ctrl[CTRL_EN_BIT] && ctrl[CTRL_ARM_BIT];
  wire paged = PAGE_SEL && !EVENT_ONLY;
  wire [16:0] paged_addr = {PAGE_REG, CPU_ADDR[13:0]};
  wire [16:0] plain_addr = {1'b0, CPU_ADDR};
  // event-only words carry no address at all
  wire [16:0] cap_addr = EVENT_ONLY ? 17'h0_0000
    : (paged ? paged_addr : plain_addr);

  // one driver for the whole entry keeps both fields in step
  assign cap_entry = {paged, cap_addr};

  dqf_ext_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .CLK(CLK),
    .RST_N(RST_N),
    .PUSH(push),
    .PUSH_ENTRY(cap_entry),
    .POP(pop),
    .HEAD(head),
    .EMPTY(st_empty),
    .FULL(st_full),
    .COUNT(st_count)
  );

  // direction qualification
  wire full_mode = cfg[CFG_FULL_BIT];
  wire a_en = cax[DIR_EN_BIT];
  wire a_val = cax[DIR_VAL_BIT];
  // in full modes comparator B follows the A direction bits
  wire b_en = full_mode ? a_en : cbx[DIR_EN_BIT];
  wire b_val = full_mode ? a_val : cbx[DIR_VAL_BIT];
  wire c_en = ccx[DIR_EN_BIT];
  wire c_val = ccx[DIR_VAL_BIT];

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      // pass out of reset: no cycle is filtered before software sets a mask
      dir_a <= 1'b1;
      dir_b <= 1'b1;
      dir_c <= 1'b1;
    end
    else
    begin
      dir_a <= dir_ok(a_en, a_val, BUS_RNW);
      dir_b <= dir_ok(b_en, b_val, BUS_RNW);
      dir_c <= dir_ok(c_en, c_val, BUS_RNW);
    end
  end

  assign DIR_OK_A = dir_a;
  assign DIR_OK_B = dir_b;
  assign DIR_OK_C = dir_c;
  assign DEBUG_ENABLE = ctrl[CTRL_EN_BIT];
  assign ARMED = ctrl[CTRL_ARM_BIT];
  assign FULL_MODE = full_mode;

endmodule

// [hw/dqf_ext_store.sv]
`timescale 1ns/1ps

module dqf_ext_store
  import dqf_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PUSH,
  input wire dqf_entry_s PUSH_ENTRY,
  input wire logic POP,
  output dqf_entry_s HEAD,
  output logic EMPTY,
  output logic FULL,
  output logic [$clog2(DEPTH+1)-1:0] COUNT
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  dqf_entry_s mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire do_push = PUSH && !FULL;
  wire do_pop = POP && !EMPTY;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign EMPTY = (count == '0);
  assign FULL = (count == CW'(DEPTH));
  assign COUNT = count;
  // an empty store reads as all zeros
  assign HEAD = EMPTY ? '0 : mem[rd_ptr];

  // only the asynchronous reset clears; an end-run reset leaves all as is
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        mem[wr_ptr] <= PUSH_ENTRY;
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_pop)
      begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// [include/dqf_pkg.sv]
package dqf_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] OFS_CAX = 8'h00;
  localparam logic [7:0] OFS_CBX = 8'h04;
  localparam logic [7:0] OFS_CCX = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_FX = 8'h10;
  localparam logic [7:0] OFS_FH = 8'h14;
  localparam logic [7:0] OFS_FL = 8'h18;
  localparam logic [7:0] OFS_CFG = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;

  // field positions
  localparam int DIR_EN_BIT = 7;
  localparam int DIR_VAL_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int FX_PAGED_BIT = 7;
  localparam int FX_MSB_BIT = 0;
  localparam int CFG_FULL_BIT = 0;
  localparam int CFG_BEGIN_BIT = 1;
  localparam int STAT_FULL_BIT = 7;
  localparam int STAT_EMPTY_BIT = 6;

  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] DIR_WMASK = 8'hc0;
  localparam logic [7:0] CTRL_WMASK = 8'hf1;
  localparam logic [7:0] CFG_WMASK = 8'h03;

  // values after reset
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_CAX = 4'b0000,
    REG_CBX = 4'b0001,
    REG_CCX = 4'b0010,
    REG_CTRL = 4'b0011,
    REG_FX = 4'b0100,
    REG_FH = 4'b0101,
    REG_FL = 4'b0110,
    REG_CFG = 4'b0111,
    REG_STAT = 4'b1000,
    REG_NONE = 4'b1111
  } dqf_reg_e;

  // one captured trace word with its extension
  typedef struct packed {
    logic paged_access_flag;
    logic [16:0] addr;
  } dqf_entry_s;

endpackage

// [tb/dqf_cpu_model.sv]
`timescale 1ns/1ps

module dqf_cpu_model
(
  input wire logic CLK,
  output logic BUS_RNW,
  output logic [15:0] CPU_ADDR,
  output logic [2:0] PAGE_REG,
  output logic PAGE_SEL,
  output logic CAPTURE,
  output logic EVENT_ONLY
);
  initial
  begin
    {BUS_RNW, CPU_ADDR, PAGE_REG, PAGE_SEL, CAPTURE, EVENT_ONLY} = '0;
  end
  task automatic cap(input logic s, input logic ev, input logic [2:0] p, input logic [15:0] a);
    @(posedge CLK);
    {PAGE_SEL, EVENT_ONLY, PAGE_REG, CPU_ADDR, CAPTURE} <= {s, ev, p, a, 1'b1};
    @(posedge CLK);
    CAPTURE <= 1'b0;
    // address moves on so a late sample cannot pass by luck
    CPU_ADDR <= ~a;
  endtask
  task automatic dir(input logic r);
    @(posedge CLK);
    BUS_RNW <= r;
  endtask
endmodule

// [tb/dqf_debug_qual_checker.sv]
`timescale 1ns/1ps

module dqf_debug_qual_checker
  import dqf_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic END_RUN_RST,
  input wire logic SECURE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic DEBUG_ENABLE,
  input wire logic ARMED,
  input wire logic DIR_OK_A,
  input wire logic DIR_OK_B,
  input wire logic DIR_OK_C
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  a_reset_dir: assert property ($rose(RST_N) |-> DIR_OK_A && DIR_OK_B && DIR_OK_C && !ARMED)
    else $error("state after reset wrong");
  a_endrun_arm: assert property (END_RUN_RST |=> !ARMED)
    else $error("arm kept over end-run reset");
  a_secure_en: assert property (SECURE |=> !DEBUG_ENABLE)
    else $error("enable set while secure");
  a_rd_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_fx_rsvd: assert property (s_rd ##0 S_AXI_ARADDR == OFS_FX |=> S_AXI_RDATA[6:1] == 6'h00)
    else $error("extension reserved bits not zero");
  a_bad_addr: assert property (s_rd ##0 S_AXI_ARADDR > OFS_STAT
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ctrl_read: assert property (s_rd ##0 S_AXI_ARADDR == OFS_CTRL
    |=> S_AXI_RDATA[7:6] == {DEBUG_ENABLE, ARMED})
    else $error("control read differs from pins");
  a_rd_lat: assert property (s_rd |=> S_AXI_RVALID)
    else $error("read answer late");
  a_wr_lat: assert property (s_wr |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
endmodule

bind dqf_debug_qual dqf_debug_qual_checker #(
  .DEPTH(DEPTH)
) u_chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .END_RUN_RST(END_RUN_RST),
  .SECURE(SECURE),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .DEBUG_ENABLE(DEBUG_ENABLE),
  .ARMED(ARMED),
  .DIR_OK_A(DIR_OK_A),
  .DIR_OK_B(DIR_OK_B),
  .DIR_OK_C(DIR_OK_C)
);

// [tb/dqf_debug_qual_test.sv]
`timescale 1ns/1ps

module dqf_debug_qual_test;
  import dqf_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, END_RUN_RST = 1'b0, SECURE = 1'b0;
  logic BUS_RNW, PAGE_SEL, CAPTURE, EVENT_ONLY;
  logic [15:0] CPU_ADDR;
  logic [2:0] PAGE_REG;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, d;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA, rd, r;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic DEBUG_ENABLE, ARMED, FULL_MODE, DIR_OK_A, DIR_OK_B, DIR_OK_C, s, ev;
  int n_mismatch = 0, compares = 0, seed = 32'h0de3;
  dqf_entry_s q[$];
  dqf_entry_s e;
  logic [7:0] rg [6] = '{OFS_CAX, OFS_CBX, OFS_CCX, OFS_CTRL, OFS_FX, OFS_CFG};

  always #12.5 CLK = ~CLK;
  dqf_debug_qual #(
    .DEPTH(4)
  ) u_dut (
    .CLK(CLK),
    .RST_N(RST_N),
    .END_RUN_RST(END_RUN_RST),
    .SECURE(SECURE),
    .BUS_RNW(BUS_RNW),
    .CPU_ADDR(CPU_ADDR),
    .PAGE_REG(PAGE_REG),
    .PAGE_SEL(PAGE_SEL),
    .CAPTURE(CAPTURE),
    .EVENT_ONLY(EVENT_ONLY),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .DEBUG_ENABLE(DEBUG_ENABLE),
    .ARMED(ARMED),
    .FULL_MODE(FULL_MODE),
    .DIR_OK_A(DIR_OK_A),
    .DIR_OK_B(DIR_OK_B),
    .DIR_OK_C(DIR_OK_C)
  );
  dqf_cpu_model u_cpu (
    .CLK(CLK),
    .BUS_RNW(BUS_RNW),
    .CPU_ADDR(CPU_ADDR),
    .PAGE_REG(PAGE_REG),
    .PAGE_SEL(PAGE_SEL),
    .CAPTURE(CAPTURE),
    .EVENT_ONLY(EVENT_ONLY)
  );

  function automatic dqf_entry_s ent(logic sl, logic eo, logic [2:0] p, logic [15:0] a);
    ent.paged_access_flag = sl & !eo;
    ent.addr = eo ? 17'h0_0000 : (sl ? {p, a[13:0]} : {1'b0, a});
  endfunction

  // extension word as read back: flag on top, address bit 16 at the bottom
  function automatic logic [31:0] fxw(dqf_entry_s x);
    fxw = {24'h00_0000, x.paged_access_flag, 6'h00, x.addr[16]};
  endfunction

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    logic ta, tw, tr, f;
    f = 1'b0;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= {24'h00_0000, wd};
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    // sampled at the falling edge: same values the next rising edge sees
    for (int i = 0; i < 40 && !f; i++)
    begin
      @(negedge CLK);
      ta = S_AXI_AWVALID & S_AXI_AWREADY;
      tw = S_AXI_WVALID & S_AXI_WREADY;
      tr = S_AXI_ARVALID & S_AXI_ARREADY;
      f = (S_AXI_BREADY & S_AXI_BVALID) | (S_AXI_RREADY & S_AXI_RVALID);
      rd = S_AXI_RDATA;
      rsp = w ? S_AXI_BRESP : S_AXI_RRESP;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      if (tr) S_AXI_ARVALID <= 1'b0;
      if (f) {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
    end
    if (!f)
    begin
      $display("CHECK FAILED %0t bus answer timed out", $time);
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    bus(1'b0, a, 8'h00);
    chk(rd, x);
    chk(32'(rsp), 32'(xr));
  endtask

  initial
  begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    foreach (rg[i]) rc(rg[i], 32'h0000_0000, RESP_OKAY);
    rc(8'h24, 32'h0000_0000, RESP_SLVERR);
    bus(1'b1, 8'h24, 8'hff);
    chk(rsp, RESP_SLVERR);
    for (int i = 1; i < 3; i++)
    begin
      bus(1'b1, rg[i], 8'hff);
      chk(rsp, RESP_OKAY);
      rc(rg[i], 32'h0000_00c0, RESP_OKAY);
    end
    for (int i = 0; i < 16; i++)
    begin
      d = {i[0], i[1], 6'h00};
      bus(1'b1, OFS_CFG, {7'h00, i[3]});
      bus(1'b1, OFS_CAX, d);
      bus(1'b1, OFS_CBX, i[3] ? ~d & 8'hc0 : d);
      bus(1'b1, OFS_CCX, d);
      u_cpu.dir(i[2]);
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      chk({DIR_OK_A, DIR_OK_B, DIR_OK_C}, {3{!i[0] | (i[1] == i[2])}});
      chk(FULL_MODE, i[3]);
    end
    bus(1'b1, OFS_CFG, 8'h00);
    bus(1'b1, OFS_CTRL, 8'hc0);
    rc(OFS_CTRL, 32'h0000_00c0, RESP_OKAY);
    // one capture beyond the depth must be dropped
    for (int i = 0; i < 5; i++)
    begin
      r = $random(seed);
      s = (r[16] | (i == 0)) & (i != 2);
      ev = (i == 1);
      u_cpu.cap(s, ev, r[19:17], r[15:0]);
      if (i < 4) q.push_back(ent(s, ev, r[19:17], r[15:0]));
    end
    rc(OFS_STAT, 32'h0000_0084, RESP_OKAY);
    while (q.size() > 0)
    begin
      e = q.pop_front();
      rc(OFS_FX, fxw(e), RESP_OKAY);
      rc(OFS_FH, {24'h00_0000, e.addr[15:8]}, RESP_OKAY);
      rc(OFS_FL, {24'h00_0000, e.addr[7:0]}, RESP_OKAY);
    end
    rc(OFS_FX, 32'h0000_0000, RESP_OKAY);
    rc(OFS_STAT, 32'h0000_0040, RESP_OKAY);
    // an entry captured before the end-run reset must survive it
    u_cpu.cap(1'b1, 1'b0, 3'h5, 16'h2abc);
    e = ent(1'b1, 1'b0, 3'h5, 16'h2abc);
    bus(1'b1, OFS_CBX, 8'h40);
    END_RUN_RST <= 1'b1;
    @(posedge CLK);
    END_RUN_RST <= 1'b0;
    @(negedge CLK);
    chk({DEBUG_ENABLE, ARMED}, 32'h0000_0002);
    rc(OFS_CBX, 32'h0000_0040, RESP_OKAY);
    rc(OFS_FX, fxw(e), RESP_OKAY);
    rc(OFS_FH, {24'h00_0000, e.addr[15:8]}, RESP_OKAY);
    rc(OFS_FL, {24'h00_0000, e.addr[7:0]}, RESP_OKAY);
    SECURE <= 1'b1;
    bus(1'b1, OFS_CTRL, 8'h80);
    rc(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    SECURE <= 1'b0;
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rc(OFS_CBX, 32'h0000_0000, RESP_OKAY);
    stop_test();
  end
endmodule
